// ==== design/sss_top.sv ====
// Vector register file with state save and restore engine
`timescale 1ns/1ps
module sss_top (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Register port
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic [31:0]       reg_rdata,
    // Save area memory, 16-byte rows, read data one cycle after mem_re
    output logic [15:0]       mem_addr,
    output logic [127:0]      mem_wdata,
    output logic              mem_we,
    output logic              mem_re,
    input  wire logic [127:0] mem_rdata,
    // Status
    output logic              busy,
    output logic              gp_fault
);
    import sss_pkg::*;

    // Architectural state
    logic [127:0] xmm_reg [16];
    logic [127:0] xmm_next [16];
    logic [79:0]  mm_reg [8];
    logic [79:0]  mm_next [8];
    logic [31:0]  csr_reg, csr_next;
    logic [31:0]  flags_reg, flags_next;
    logic [15:0]  fcw_reg, fcw_next;
    logic [15:0]  fsw_reg, fsw_next;
    logic [15:0]  fop_reg, fop_next;
    logic [7:0]   empty_reg, empty_next;
    logic [63:0]  gpr_reg, gpr_next;

    // Control state
    sss_state_t   state_reg, state_next;
    logic         mode64_reg, mode64_next;
    logic         width_reg, width_next;
    logic [15:0]  base_reg, base_next;
    logic [8:0]   vsel_reg, vsel_next;
    logic [4:0]   cnt_reg, cnt_next;
    logic [4:0]   iss_row_reg, iss_row_next;
    logic [4:0]   pipe_row_reg, pipe_row_next;
    logic         pipe_vld_reg, pipe_vld_next;
    logic         fault_reg, fault_next;
    logic         done_reg, done_next;

    // Output flops
    logic [31:0]  rdata_next;
    logic [15:0]  addr_next;
    logic [127:0] wdata_next;
    logic         we_next, re_next, busy_next, gp_next;

    // Helpers
    logic         wr_csr_legal, rd_csr_legal;
    logic         cmp_eq, cmp_lt;
    logic [3:0]   idx_mask, src_a, src_b, vidx;
    logic [4:0]   last_row;
    logic [127:0] save_row;
    logic [4:0]   rel;

    // Restricted register numbers outside 64-bit mode; the mode is the extension prefix's enable
    assign idx_mask = mode64_reg ? 4'hF : 4'h7;
    assign src_a    = reg_wdata[SSS_CTRL_SRCA +: 4] & (reg_wdata[SSS_CTRL_MODE64] ? 4'hF : 4'h7);
    assign src_b    = reg_wdata[SSS_CTRL_SRCB +: 4] & (reg_wdata[SSS_CTRL_MODE64] ? 4'hF : 4'h7);
    assign vidx     = vsel_reg[SSS_VSEL_IDX +: 4] & idx_mask;
    assign last_row = mode64_reg ? SSS_ROW_LAST64 : SSS_ROW_LAST32;

    sss_csr_check u_wr_check (
        .value (reg_wdata),
        .legal (wr_csr_legal)
    );

    sss_csr_check u_rd_check (
        .value (mem_rdata[SSS_CSR_LSB +: 32]),
        .legal (rd_csr_legal)
    );

    sss_lowq_cmp u_cmp (
        .src_a (xmm_reg[src_a]),
        .src_b (xmm_reg[src_b]),
        .equal (cmp_eq),
        .less  (cmp_lt)
    );

    // Image of one save area row, built from live state
    always_comb begin
        save_row = 128'h0;
        rel      = 5'h00;
        if (cnt_reg == SSS_ROW_X87) begin
            save_row[15:0]                = fcw_reg;
            save_row[31:16]               = fsw_reg;
            save_row[SSS_TAG_LSB +: 8]    = ~empty_reg;
            save_row[SSS_FOP_LSB +: 16]   = fop_reg;
        end else if (cnt_reg == SSS_ROW_CSR) begin
            save_row[SSS_CSR_LSB +: 32]   = csr_reg;
            save_row[SSS_CSR_LSB+32 +: 32] = SSS_CSR_MASK;
        end else if (cnt_reg < SSS_ROW_WIDE_VECTOR_REGISTER_ZERO) begin
            rel            = cnt_reg - SSS_ROW_MM0;
            save_row[79:0] = mm_reg[rel[2:0]];
        end else begin
            rel      = cnt_reg - SSS_ROW_WIDE_VECTOR_REGISTER_ZERO;
            save_row = xmm_reg[rel[3:0]];
        end
    end

    always_comb begin
        xmm_next      = xmm_reg;
        mm_next       = mm_reg;
        csr_next      = csr_reg;
        flags_next    = flags_reg;
        fcw_next      = fcw_reg;
        fsw_next      = fsw_reg;
        fop_next      = fop_reg;
        empty_next    = empty_reg;
        gpr_next      = gpr_reg;
        state_next    = state_reg;
        mode64_next   = mode64_reg;
        width_next    = width_reg;
        base_next     = base_reg;
        vsel_next     = vsel_reg;
        cnt_next      = cnt_reg;
        iss_row_next  = iss_row_reg;
        pipe_row_next = iss_row_reg;
        pipe_vld_next = mem_re;
        fault_next    = fault_reg;
        done_next     = done_reg;
        rdata_next    = 32'h0000_0000;
        addr_next     = mem_addr;
        wdata_next    = mem_wdata;
        we_next       = 1'b0;
        re_next       = 1'b0;
        gp_next       = 1'b0;

        // Software writes; clears of sticky bits come first so hardware sets win
        if (reg_wr) begin
            case (reg_addr)
                SSS_REG_STATUS: begin
                    if (reg_wdata[SSS_ST_FAULT]) fault_next = 1'b0;
                    if (reg_wdata[SSS_ST_DONE])  done_next  = 1'b0;
                end
                SSS_REG_CSR: begin
                    if (wr_csr_legal) csr_next = reg_wdata;
                    else begin
                        fault_next = 1'b1;
                        gp_next    = 1'b1;
                    end
                end
                SSS_REG_FLAGS: flags_next = reg_wdata;
                SSS_REG_VSEL:  vsel_next  = reg_wdata[8:0];
                SSS_REG_BASE:  base_next  = reg_wdata[15:0];
                SSS_REG_VDATA: begin
                    if (state_reg == SSS_IDLE) begin
                        if (!vsel_reg[SSS_VSEL_KIND]) begin
                            xmm_next[vidx][vsel_reg[SSS_VSEL_LANE +: 2]*32 +: 32] = reg_wdata;
                        end else begin
                            case (vsel_reg[SSS_VSEL_LANE +: 2])
                                2'h0:    mm_next[vidx[2:0]][31:0]  = reg_wdata;
                                2'h1:    mm_next[vidx[2:0]][63:32] = reg_wdata;
                                2'h2:    mm_next[vidx[2:0]][79:64] = reg_wdata[15:0];
                                default: ;
                            endcase
                            empty_next[vidx[2:0]] = 1'b0;
                        end
                    end
                end
                SSS_REG_CTRL: begin
                    if (state_reg == SSS_IDLE) begin
                        mode64_next = reg_wdata[SSS_CTRL_MODE64];
                        width_next  = reg_wdata[SSS_CTRL_WIDTH];
                        if (reg_wdata[SSS_CTRL_SAVE]) begin
                            state_next = SSS_SAVE;
                            cnt_next   = SSS_ROW_X87;
                        end else if (reg_wdata[SSS_CTRL_RSTR]) begin
                            state_next = SSS_R_ISSUE;
                            re_next    = 1'b1;
                            addr_next  = base_reg + {11'h0, SSS_ROW_CSR};
                        end else if (reg_wdata[SSS_CTRL_CMP]) begin
                            // Width bit has no meaning for a compare; it is still latched into width_reg but unused here
                            flags_next                = 32'h0000_0000;
                            flags_next[SSS_FLAG_ZF]   = cmp_eq;
                            flags_next[SSS_FLAG_CF]   = cmp_lt;
                            flags_next[1]             = 1'b1;
                        end else if (reg_wdata[SSS_CTRL_MOVG]) begin
                            gpr_next = reg_wdata[SSS_CTRL_WIDTH] ? xmm_reg[src_a][63:0]
                                                                 : {32'h0000_0000, xmm_reg[src_a][31:0]};
                        end
                    end
                end
                default: ;
            endcase
        end

        // Software reads, data stands in the following cycle only
        if (reg_rd) begin
            case (reg_addr)
                SSS_REG_CTRL:   rdata_next = {22'h0, width_reg, mode64_reg, 8'h00};
                SSS_REG_STATUS: rdata_next = {29'h0, done_reg, fault_reg, (state_reg != SSS_IDLE)};
                SSS_REG_CSR:    rdata_next = csr_reg;
                SSS_REG_FLAGS:  rdata_next = flags_reg;
                SSS_REG_IDENT:  rdata_next = SSS_IDENT_EDX;
                SSS_REG_VSEL:   rdata_next = {23'h0, vsel_reg};
                SSS_REG_BASE:   rdata_next = {16'h0, base_reg};
                SSS_REG_GPR_LO: rdata_next = gpr_reg[31:0];
                SSS_REG_GPR_HI: rdata_next = gpr_reg[63:32];
                SSS_REG_X87:    rdata_next = {fsw_reg, fcw_reg};
                SSS_REG_VDATA: begin
                    if (!vsel_reg[SSS_VSEL_KIND]) begin
                        rdata_next = xmm_reg[vidx][vsel_reg[SSS_VSEL_LANE +: 2]*32 +: 32];
                    end else begin
                        case (vsel_reg[SSS_VSEL_LANE +: 2])
                            2'h0:    rdata_next = mm_reg[vidx[2:0]][31:0];
                            2'h1:    rdata_next = mm_reg[vidx[2:0]][63:32];
                            2'h2:    rdata_next = {16'h0, mm_reg[vidx[2:0]][79:64]};
                            default: rdata_next = 32'h0000_0000;
                        endcase
                    end
                end
                default:        rdata_next = 32'h0000_0000;
            endcase
        end

        // Save and restore sequencer
        case (state_reg)
            SSS_IDLE: ;
            SSS_SAVE: begin
                we_next    = 1'b1;
                addr_next  = base_reg + {11'h0, cnt_reg};
                wdata_next = save_row;
                cnt_next   = cnt_reg + 5'h01;
                if (cnt_reg == last_row) begin
                    state_next = SSS_IDLE;
                    done_next  = 1'b1;
                end
            end
            SSS_R_ISSUE: state_next = SSS_R_CHECK;
            SSS_R_CHECK: begin
                if (!rd_csr_legal) begin
                    state_next = SSS_IDLE;
                    fault_next = 1'b1;
                    gp_next    = 1'b1;
                end else begin
                    state_next   = SSS_R_LOAD;
                    re_next      = 1'b1;
                    addr_next    = base_reg + {11'h0, SSS_ROW_X87};
                    iss_row_next = SSS_ROW_X87;
                    cnt_next     = SSS_ROW_X87 + 5'h01;
                end
            end
            SSS_R_LOAD: begin
                if (cnt_reg <= last_row) begin
                    re_next      = 1'b1;
                    addr_next    = base_reg + {11'h0, cnt_reg};
                    iss_row_next = cnt_reg;
                    cnt_next     = cnt_reg + 5'h01;
                end else begin
                    state_next = SSS_R_DRAIN;
                end
            end
            SSS_R_DRAIN: begin
                if (!mem_re && !pipe_vld_reg) begin
                    state_next = SSS_IDLE;
                    done_next  = 1'b1;
                end
            end
            default: state_next = SSS_IDLE;
        endcase

        // Returned rows are applied only once the control value passed
        if (pipe_vld_reg && (state_reg == SSS_R_LOAD || state_reg == SSS_R_DRAIN)) begin
            if (pipe_row_reg == SSS_ROW_X87) begin
                fcw_next   = mem_rdata[15:0];
                fsw_next   = mem_rdata[31:16];
                empty_next = ~mem_rdata[SSS_TAG_LSB +: 8];
                fop_next   = mem_rdata[SSS_FOP_LSB +: 16];
            end else if (pipe_row_reg == SSS_ROW_CSR) begin
                csr_next = mem_rdata[SSS_CSR_LSB +: 32];
            end else if (pipe_row_reg < SSS_ROW_WIDE_VECTOR_REGISTER_ZERO) begin
                mm_next[3'(pipe_row_reg - SSS_ROW_MM0)] = mem_rdata[79:0];
            end else begin
                xmm_next[4'(pipe_row_reg - SSS_ROW_WIDE_VECTOR_REGISTER_ZERO)] = mem_rdata;
            end
        end

        busy_next = (state_next != SSS_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) xmm_reg[i] <= 128'h0;
            for (int i = 0; i < 8; i++)  mm_reg[i]  <= 80'h0;
            csr_reg      <= SSS_CSR_RST;
            flags_reg    <= SSS_FLAGS_RST;
            fcw_reg      <= SSS_FCW_RST;
            fsw_reg      <= 16'h0000;
            fop_reg      <= 16'h0000;
            empty_reg    <= SSS_TAGS_RST;
            gpr_reg      <= 64'h0;
            state_reg    <= SSS_IDLE;
            mode64_reg   <= 1'b0;
            width_reg    <= 1'b0;
            base_reg     <= 16'h0000;
            vsel_reg     <= 9'h000;
            cnt_reg      <= 5'h00;
            iss_row_reg  <= 5'h00;
            pipe_row_reg <= 5'h00;
            pipe_vld_reg <= 1'b0;
            fault_reg    <= 1'b0;
            done_reg     <= 1'b0;
            reg_rdata    <= 32'h0000_0000;
            mem_addr     <= 16'h0000;
            mem_wdata    <= 128'h0;
            mem_we       <= 1'b0;
            mem_re       <= 1'b0;
            busy         <= 1'b0;
            gp_fault     <= 1'b0;
        end else begin
            xmm_reg      <= xmm_next;
            mm_reg       <= mm_next;
            csr_reg      <= csr_next;
            flags_reg    <= flags_next;
            fcw_reg      <= fcw_next;
            fsw_reg      <= fsw_next;
            fop_reg      <= fop_next;
            empty_reg    <= empty_next;
            gpr_reg      <= gpr_next;
            state_reg    <= state_next;
            mode64_reg   <= mode64_next;
            width_reg    <= width_next;
            base_reg     <= base_next;
            vsel_reg     <= vsel_next;
            cnt_reg      <= cnt_next;
            iss_row_reg  <= iss_row_next;
            pipe_row_reg <= pipe_row_next;
            pipe_vld_reg <= pipe_vld_next;
            fault_reg    <= fault_next;
            done_reg     <= done_next;
            reg_rdata    <= rdata_next;
            mem_addr     <= addr_next;
            mem_wdata    <= wdata_next;
            mem_we       <= we_next;
            mem_re       <= re_next;
            busy         <= busy_next;
            gp_fault     <= gp_next;
        end
    end

endmodule : sss_top

// ==== design/sss_pkg.sv ====
// Shared constants and types for the vector state save and restore block
package sss_pkg;

    // Register map, byte offsets
    localparam logic [7:0]   SSS_REG_CTRL    = 8'h00;
    localparam logic [7:0]   SSS_REG_STATUS  = 8'h04;
    localparam logic [7:0]   SSS_REG_CSR     = 8'h08;
    localparam logic [7:0]   SSS_REG_FLAGS   = 8'h0C;
    localparam logic [7:0]   SSS_REG_IDENT   = 8'h10;
    localparam logic [7:0]   SSS_REG_VSEL    = 8'h14;
    localparam logic [7:0]   SSS_REG_VDATA   = 8'h18;
    localparam logic [7:0]   SSS_REG_BASE    = 8'h1C;
    localparam logic [7:0]   SSS_REG_GPR_LO  = 8'h20;
    localparam logic [7:0]   SSS_REG_GPR_HI  = 8'h24;
    localparam logic [7:0]   SSS_REG_X87     = 8'h28;

    // Control register fields
    localparam int           SSS_CTRL_SAVE   = 0;
    localparam int           SSS_CTRL_RSTR   = 1;
    localparam int           SSS_CTRL_CMP    = 2;
    localparam int           SSS_CTRL_MOVG   = 3;
    localparam int           SSS_CTRL_MODE64 = 8;
    localparam int           SSS_CTRL_WIDTH  = 9;
    localparam int           SSS_CTRL_SRCA   = 16;
    localparam int           SSS_CTRL_SRCB   = 20;

    // Status register fields
    localparam int           SSS_ST_BUSY     = 0;
    localparam int           SSS_ST_FAULT    = 1;
    localparam int           SSS_ST_DONE     = 2;

    // Register select fields
    localparam int           SSS_VSEL_IDX    = 0;
    localparam int           SSS_VSEL_LANE   = 4;
    localparam int           SSS_VSEL_KIND   = 8;

    // Flags register bit positions and reset value
    localparam int           SSS_FLAG_CF     = 0;
    localparam int           SSS_FLAG_ZF     = 6;
    localparam logic [31:0]  SSS_FLAGS_RST   = 32'h0000_0002;

    // Identification word: double-precision vector extension present at bit 26
    localparam logic [31:0]  SSS_IDENT_EDX   = 32'h0400_0000;

    // Control/status register: reset, legal bits, mask image stored on save
    localparam logic [31:0]  SSS_CSR_RST     = 32'h0000_1F80;
    localparam logic [31:0]  SSS_CSR_LEGAL   = 32'h0000_FFFF;
    localparam logic [31:0]  SSS_CSR_MASK    = 32'h0000_FFFF;
    localparam int           SSS_CSR_DAZ     = 6;
    localparam int           SSS_CSR_FTZ     = 15;

    // Legacy stack defaults
    localparam logic [15:0]  SSS_FCW_RST     = 16'h037F;
    localparam logic [7:0]   SSS_TAGS_RST    = 8'hFF;

    // Save area layout in 16-byte rows
    localparam logic [4:0]   SSS_ROW_X87     = 5'h00;
    localparam logic [4:0]   SSS_ROW_CSR     = 5'h01;
    localparam logic [4:0]   SSS_ROW_MM0     = 5'h02;
    localparam logic [4:0]   SSS_ROW_WIDE_VECTOR_REGISTER_ZERO    = 5'h0A;
    localparam logic [4:0]   SSS_ROW_XMM8    = 5'h12;
    localparam logic [4:0]   SSS_ROW_LAST32  = 5'h11;
    localparam logic [4:0]   SSS_ROW_LAST64  = 5'h19;

    // Byte 27:24 of the area sits at row 1 bits 95:64, mask at 127:96
    localparam int           SSS_CSR_LSB     = 64;
    localparam int           SSS_TAG_LSB     = 32;
    localparam int           SSS_FOP_LSB     = 48;

    typedef enum logic [2:0] {
        SSS_IDLE,
        SSS_SAVE,
        SSS_R_ISSUE,
        SSS_R_CHECK,
        SSS_R_LOAD,
        SSS_R_DRAIN
    } sss_state_t;

endpackage : sss_pkg

// ==== design/sss_csr_check.sv ====
// Legality check of a control/status value
`timescale 1ns/1ps
module sss_csr_check (
    // Value under test
    input  wire logic [31:0] value,
    // Result
    output logic             legal
);
    import sss_pkg::*;

    // Any bit outside the defined field set is reserved
    always_comb begin
        legal = ((value & ~SSS_CSR_LEGAL) == 32'h0000_0000);
    end

endmodule : sss_csr_check

// ==== design/sss_lowq_cmp.sv ====
// Compare of the low quadwords of two wide vector registers
`timescale 1ns/1ps
module sss_lowq_cmp (
    // Operands
    input  wire logic [127:0] src_a,
    input  wire logic [127:0] src_b,
    // Outcome
    output logic              equal,
    output logic              less
);
    import sss_pkg::*;

    // Scalar operands live in bits 63:0 only
    always_comb begin
        equal = (src_a[63:0] == src_b[63:0]);
        less  = (src_a[63:0] < src_b[63:0]);
    end

endmodule : sss_lowq_cmp

// ==== verif/sss_top_monitor.sv ====
// Port checker for the save and restore block
`timescale 1ns/1ps
module sss_top_monitor
    import sss_pkg::*;
(
    // Clock and reset
    input wire logic         sys_clk,
    input wire logic         rst,
    // Register port
    input wire logic [7:0]   reg_addr,
    input wire logic [31:0]  reg_wdata,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [31:0]  reg_rdata,
    // Memory and status
    input wire logic [15:0]  mem_addr,
    input wire logic [127:0] mem_wdata,
    input wire logic         mem_we,
    input wire logic         mem_re,
    input wire logic [127:0] mem_rdata,
    input wire logic         busy,
    input wire logic         gp_fault
);
    logic [15:0] base_reg;
    logic [15:0] base_next;
    always_comb begin
        base_next = base_reg;
        if (reg_wr && reg_addr == SSS_REG_BASE) base_next = reg_wdata[15:0];
    end
    always_ff @(posedge sys_clk) base_reg <= rst ? 16'h0000 : base_next;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence go(b);
        reg_wr && reg_addr == SSS_REG_CTRL && !busy && reg_wdata[b];
    endsequence
    sequence save32;
        go(SSS_CTRL_SAVE) ##0 !reg_wdata[SSS_CTRL_MODE64];
    endsequence
    sequence save64;
        go(SSS_CTRL_SAVE) ##0 reg_wdata[SSS_CTRL_MODE64];
    endsequence
    sequence rstr;
        go(SSS_CTRL_RSTR) ##0 !reg_wdata[SSS_CTRL_SAVE];
    endsequence
    save_start_a: assert property (save32 |-> ##2 mem_we && mem_addr == base_reg)
        else $error("save did not start at area base");
    save_busy_a: assert property (save32 |=> busy [*8])
        else $error("busy dropped during save");
    save_span_a: assert property (save32 |-> ##19 (mem_we && mem_addr == base_reg + 16'h11)
        ##1 !mem_we)
        else $error("short save row span wrong");
    wide_span_a: assert property (save64 |-> ##27 (mem_we && mem_addr == base_reg + 16'h19)
        ##1 !mem_we)
        else $error("wide save row span wrong");
    check_first_a: assert property (rstr |-> ##1 mem_re && !mem_we && mem_addr == base_reg + 16'h01)
        else $error("restore did not read control row first");
    // A refused control write in the same cycle legally starts a second pulse
    fault_pulse_a: assert property (gp_fault && !(reg_wr && reg_addr == SSS_REG_CSR) |=> !gp_fault)
        else $error("fault pulse longer than one cycle");
    csr_refuse_a: assert property (
        reg_wr && reg_addr == SSS_REG_CSR && reg_wdata[31:16] != 16'h0 |=> gp_fault)
        else $error("illegal control value accepted");
    ident_bit_a: assert property (reg_rd && reg_addr == SSS_REG_IDENT |=> reg_rdata == SSS_IDENT_EDX)
        else $error("identification word wrong");
endmodule : sss_top_monitor
bind sss_top sss_top_monitor u_mon (.*);

// ==== verif/sss_mem_model.sv ====
// Save area memory that answers one cycle after each read
`timescale 1ns/1ps
module sss_mem_model (
    // Clock
    input wire logic         sys_clk,
    // Row access
    input wire logic [15:0]  mem_addr,
    input wire logic [127:0] mem_wdata,
    input wire logic         mem_we,
    input wire logic         mem_re,
    output logic [127:0]     mem_rdata
);
    logic [127:0] ram [0:63];
    initial mem_rdata = 128'h0;
    // Data stands one cycle, then the line flips so stale rows never pass
    always @(posedge sys_clk) begin
        if (mem_we) ram[mem_addr[5:0]] <= mem_wdata;
        mem_rdata <= mem_re ? ram[mem_addr[5:0]] : ~mem_rdata;
    end
endmodule : sss_mem_model

// ==== verif/testbench.sv ====
// Self-checking bench for the save and restore block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; $display("BAD %0t %h %h", $time, a, e); end end
module testbench;
    import sss_pkg::*;
    logic         sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [31:0]  reg_wdata = 32'h0, reg_rdata;
    logic [15:0]  mem_addr;
    logic [127:0] mem_wdata, mem_rdata;
    logic         mem_we, mem_re, busy, gp_fault;
    logic [127:0] v = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    int           n_errors = 0, total_checks = 0;
    sss_top uut (.*);
    sss_mem_model mem (.*);
    initial forever #25 sys_clk = ~sys_clk;
    task tally_and_finish;
        if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rc
    task rv(input logic [3:0] i, input logic [31:0] e);
        wr(SSS_REG_VSEL, {28'h0, i});
        rc(SSS_REG_VDATA, e);
    endtask : rv
    task setv(input logic [3:0] i, input logic [127:0] d);
        for (int l = 0; l < 4; l++) begin
            wr(SSS_REG_VSEL, {26'h0, 2'(l), i});
            wr(SSS_REG_VDATA, d[l*32+:32]);
        end
    endtask : setv
    task op(input logic [31:0] c);
        wr(SSS_REG_CTRL, c);
        for (int i = 0; i < 60 && (i < 3 || busy); i++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask : op
    initial begin
        for (int r = 0; r < 64; r++) mem.ram[r] = {4{32'h5A5A_A5A5}};
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rc(SSS_REG_IDENT, 32'h0400_0000);
        rc(SSS_REG_FLAGS, 32'h0000_0002);
        rc(8'hFC, 32'h0);
        wr(SSS_REG_CSR, 32'h0001_0000);
        rc(SSS_REG_CSR, 32'h0000_1F80);
        rc(SSS_REG_STATUS, 32'h0000_0002);
        wr(SSS_REG_CSR, 32'h0000_8040);
        rc(SSS_REG_CSR, 32'h0000_8040);
        setv(4'h3, v);
        wr(SSS_REG_BASE, 32'h20);
        op(32'h1);
        `CHK(mem.ram[6'h2D], v)
        `CHK(mem.ram[6'h21][127:64], 64'h0000_FFFF_0000_8040)
        `CHK(mem.ram[6'h20][39:32], 8'h00)
        `CHK(mem.ram[6'h32], {4{32'h5A5A_A5A5}})
        mem.ram[6'h2D] = ~v;
        mem.ram[6'h21][95:64] = 32'h0001_1F80;
        wr(SSS_REG_STATUS, 32'h6);
        op(32'h2);
        rc(SSS_REG_STATUS, 32'h2);
        rv(4'h3, 32'h7654_3210);
        rc(SSS_REG_CSR, 32'h8040);
        mem.ram[6'h21][127:64] = 64'hFFFF_FFFF_0000_1F80;
        wr(SSS_REG_STATUS, 32'h6);
        op(32'h2);
        rc(SSS_REG_STATUS, 32'h4);
        rc(SSS_REG_CSR, 32'h1F80);
        rv(4'h3, 32'h89AB_CDEF);
        op(32'h0033_0004);
        rc(SSS_REG_FLAGS, 32'h42);
        op(32'h0030_0004);
        rc(SSS_REG_FLAGS, 32'h3);
        op(32'h0033_0204);
        rc(SSS_REG_FLAGS, 32'h42);
        op(32'h0003_0208);
        rc(SSS_REG_GPR_HI, 32'h0123_4567);
        op(32'h0003_0008);
        rc(SSS_REG_GPR_LO, 32'h89AB_CDEF);
        rc(SSS_REG_GPR_HI, 32'h0);
        wr(SSS_REG_CTRL, 32'h100);
        setv(4'h9, v);
        // Packed integer register 2, low lane, marks its tag non-empty
        wr(SSS_REG_VSEL, 32'h0000_0102);
        wr(SSS_REG_VDATA, 32'hCAFE_0001);
        rc(SSS_REG_VDATA, 32'hCAFE_0001);
        op(32'h101);
        `CHK(mem.ram[6'h33], v)
        `CHK(mem.ram[6'h20][39:32], 8'h04)
        `CHK(mem.ram[6'h24][79:0], 80'h0000_0000_0000_CAFE_0001)
        tally_and_finish();
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        n_errors++;
        tally_and_finish();
    end
endmodule : testbench
